// File: verilog/afe_cfg_pkg.sv
// ****************************************************************
// Constants shared by the configuration bank and its serial engine
// ****************************************************************
package afe_cfg_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [5:0] OFS_TRANSMIT = 6'h00;
  localparam logic [5:0] OFS_RX_COUNT = 6'h01;
  localparam logic [5:0] OFS_MODE = 6'h02;
  localparam logic [5:0] OFS_TEMP_ECHO = 6'h03;
  localparam logic [5:0] OFS_RX_PHASE = 6'h04;
  localparam logic [5:0] OFS_GAIN_HI = 6'h05;
  localparam logic [5:0] OFS_GAIN_LO = 6'h06;

  // Values after reset
  localparam logic [7:0] RST_TRANSMIT = 8'h45;
  localparam logic [7:0] RST_RX_COUNT = 8'h40;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_TEMP_ECHO = 8'h03;
  localparam logic [7:0] RST_RX_PHASE = 8'h1F;
  localparam logic [7:0] RST_GAIN_HI = 8'h00;
  localparam logic [7:0] RST_GAIN_LO = 8'h00;

  // Field positions
  localparam int TX_DIV_LSB = 5;
  localparam int RX_CNT_LSB = 0;
  localparam int MODE_REF_BIT = 7;
  localparam int MODE_MEAS_BIT = 6;
  localparam int MODE_DAMP_BIT = 5;
  localparam int TE_CHAN_BIT = 6;
  localparam int TE_SENSOR_BIT = 5;
  localparam int TE_CLKDIV_BIT = 4;
  localparam int TE_BLANK_BIT = 3;
  localparam int RP_RXMODE_BIT = 6;
  localparam int RP_EDGE_BIT = 5;
  localparam int GH_GAIN_LSB = 5;
  localparam int GH_BYP2_BIT = 4;
  localparam int GH_BYP1_BIT = 3;
  localparam int GH_FB_BIT = 2;

  // Decoded values
  localparam logic [5:0] STOP_COUNT_FREE = 6'h20;
  localparam logic [2:0] TEMP_DIV8_CODE = 3'h2;

  // Command byte layout
  localparam int CMD_RSV_BIT = 7;
  localparam int CMD_RW_BIT = 6;
  localparam logic CMD_WRITE = 1'b1;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_READ = 2'b01,
    PH_WRITE = 2'b10,
    PH_DONE = 2'b11
  } phase_t;

endpackage : afe_cfg_pkg

// File: verilog/spi_frame_if.sv
`timescale 1ns/1ns
// ****************************************************************
// Decoded register access between serial engine and bank
// ****************************************************************
interface spi_frame_if;
  logic [5:0] addr;
  logic wrStrobe;
  logic [7:0] wrData;
  logic [7:0] rdData;

  modport engine (output addr, output wrStrobe, output wrData,
    input rdData);
  modport bank (input addr, input wrStrobe, input wrData,
    output rdData);
endinterface : spi_frame_if

// File: verilog/spi_frame_engine.sv
`timescale 1ns/1ns
// ****************************************************************
// Serial frame engine: command byte then one data byte
// ****************************************************************
module spi_frame_engine
  import afe_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic sclkLvl,
  input wire logic csbNLvl,
  input wire logic sdiLvl,
  spi_frame_if.engine bus,
  output logic sdo,
  output logic sdoOeN
);

  phase_t state_r;
  logic sclkPrev_r;
  logic [2:0] bitCnt_r;
  logic [7:0] shiftIn_r;
  logic [7:0] outShift_r;
  logic [5:0] addr_r;
  logic [7:0] wrData_r;
  logic wrStrobe_r;
  logic loadPend_r;
  logic sampled_r;

  // Edge and frame decode on synchronised levels
  wire active = ~csbNLvl;
  wire rise = sclkLvl & ~sclkPrev_r;
  wire fall = ~sclkLvl & sclkPrev_r;
  wire [7:0] shiftIn_nxt = {shiftIn_r[6:0], sdiLvl};
  wire byteDone = rise && (bitCnt_r == LAST_BIT);
  wire cmdBad = shiftIn_nxt[CMD_RSV_BIT];
  wire cmdWrite = (shiftIn_nxt[CMD_RW_BIT] == CMD_WRITE);

  // SCLK history for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      sclkPrev_r <= 1'b1;  // Same level as synchroniser reset
    end else if (clkEn) begin
      sclkPrev_r <= sclkLvl;
    end
  end

  // Frame sequencing; chip select high aborts any frame
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= PH_CMD;
      bitCnt_r <= 3'h0;
      shiftIn_r <= 8'h00;
      addr_r <= 6'h00;
      wrData_r <= 8'h00;
      wrStrobe_r <= 1'b0;
      loadPend_r <= 1'b0;
    end else if (clkEn) begin
      wrStrobe_r <= 1'b0;
      loadPend_r <= 1'b0;
      if (!active) begin
        state_r <= PH_CMD;
        bitCnt_r <= 3'h0;
      end else if (rise && state_r != PH_DONE) begin
        shiftIn_r <= shiftIn_nxt;
        bitCnt_r <= bitCnt_r + 3'h1;
        if (byteDone) begin
          case (state_r)
            PH_CMD: begin
              addr_r <= shiftIn_nxt[5:0];
              loadPend_r <= ~cmdBad & ~cmdWrite;
              if (cmdBad) state_r <= PH_DONE;
              else if (cmdWrite) state_r <= PH_WRITE;
              else state_r <= PH_READ;
            end
            PH_WRITE: begin
              wrData_r <= shiftIn_nxt;
              wrStrobe_r <= 1'b1;
              state_r <= PH_DONE;
            end
            default: state_r <= PH_DONE;
          endcase
        end
      end
    end
  end

  // Read data shifts out MSB first, one bit per falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      outShift_r <= 8'h00;
      sampled_r <= 1'b0;
    end else if (clkEn) begin
      if (loadPend_r) begin
        outShift_r <= bus.rdData;
        sampled_r <= 1'b0;
      end else if (state_r == PH_READ && active) begin
        if (rise) sampled_r <= 1'b1;
        else if (fall && sampled_r) begin
          outShift_r <= {outShift_r[6:0], 1'b0};
          sampled_r <= 1'b0;
        end
      end
    end
  end

  // Bus and pin outputs
  assign bus.addr = addr_r;
  assign bus.wrData = wrData_r;
  assign bus.wrStrobe = wrStrobe_r;
  assign sdo = outShift_r[7];
  assign sdoOeN = ~(active && state_r == PH_READ);

endmodule : spi_frame_engine

// File: verilog/ultrasonic_afe_config_regs.sv
`timescale 1ns/1ns
module ultrasonic_afe_config_regs
  import afe_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic sclk,
  input wire logic csbN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOeN,
  output logic [2:0] transmitFreqDivider,
  output logic [4:0] transmitPulseCount,
  output logic [2:0] expectedRxCount,
  output logic eventCountEnable,
  output logic [5:0] stopPulseCount,
  output logic commonModeRefSelect,
  output logic measureTypeSelect,
  output logic dampingEnable,
  output logic tempChannelSelect,
  output logic sensorTypeSelect,
  output logic tempClkUseTxDiv,
  output logic [2:0] tempClkDivider,
  output logic blankingEnable,
  output logic [2:0] echoThresholdCode,
  output logic receiveModeSelect,
  output logic triggerEdgeSelect,
  output logic [4:0] phaseFlipPosition,
  output logic [2:0] secondAmpGainCode,
  output logic secondAmpBypass,
  output logic firstAmpBypass,
  output logic firstAmpFeedbackSelect,
  output logic [9:0] flightTimeTiming
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  logic [2:0] pinRaw;
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;

  // Pins gathered so one loop serves all three
  assign pinRaw = {sclk, csbN, sdi};

  // Two flops per pin; only the second stage is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gSync
      always_ff @(posedge clk) begin
        if (rst) begin
          syncA_r[gi] <= 1'b1;
          syncB_r[gi] <= 1'b1;
        end else if (clkEn) begin
          syncA_r[gi] <= pinRaw[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate

  // Synchronised levels handed to the frame engine
  wire sclkSync = syncB_r[2];
  wire csbNSync = syncB_r[1];
  wire sdiSync = syncB_r[0];

  // ****************************************************************
  // Serial frame engine
  // ****************************************************************

  spi_frame_if frameBus ();

  spi_frame_engine engine (
    .clk (clk),
    .rst (rst),
    .clkEn (clkEn),
    .sclkLvl (sclkSync),
    .csbNLvl (csbNSync),
    .sdiLvl (sdiSync),
    .bus (frameBus.engine),
    .sdo (sdo),
    .sdoOeN (sdoOeN)
  );

  // ****************************************************************
  // Register storage
  // ****************************************************************

  logic [7:0] transmit_r;
  logic [7:0] rxCount_r;
  logic [7:0] mode_r;
  logic [7:0] tempEcho_r;
  logic [7:0] rxPhase_r;
  logic [7:0] gainHi_r;
  logic [7:0] gainLo_r;
  logic [5:0] stopCount_r;
  logic [2:0] tempDiv_r;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // One select per register, shared by write and read back
  wire selTransmit = frameBus.addr == OFS_TRANSMIT;
  wire selRxCount = frameBus.addr == OFS_RX_COUNT;
  wire selMode = frameBus.addr == OFS_MODE;
  wire selTempEcho = frameBus.addr == OFS_TEMP_ECHO;
  wire selRxPhase = frameBus.addr == OFS_RX_PHASE;
  wire selGainHi = frameBus.addr == OFS_GAIN_HI;
  wire selGainLo = frameBus.addr == OFS_GAIN_LO;

  // Write decode, one strobe per register
  wire wrTransmit = frameBus.wrStrobe && selTransmit;
  wire wrRxCount = frameBus.wrStrobe && selRxCount;
  wire wrMode = frameBus.wrStrobe && selMode;
  wire wrTempEcho = frameBus.wrStrobe && selTempEcho;
  wire wrRxPhase = frameBus.wrStrobe && selRxPhase;
  wire wrGainHi = frameBus.wrStrobe && selGainHi;
  wire wrGainLo = frameBus.wrStrobe && selGainLo;

  // ****************************************************************
  // Register update
  // ****************************************************************

  // Transmit divider and pulse count
  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_r <= RST_TRANSMIT;
    end else if (clkEn && wrTransmit) begin
      transmit_r <= frameBus.wrData;
    end
  end

  // Receive count; reserved upper bits stored as written
  always_ff @(posedge clk) begin
    if (rst) begin
      rxCount_r <= RST_RX_COUNT;
    end else if (clkEn && wrRxCount) begin
      rxCount_r <= frameBus.wrData;
    end
  end

  // Reference, measurement type and damping
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= RST_MODE;
    end else if (clkEn && wrMode) begin
      mode_r <= frameBus.wrData;
    end
  end

  // Temperature options, blanking and echo threshold
  always_ff @(posedge clk) begin
    if (rst) begin
      tempEcho_r <= RST_TEMP_ECHO;
    end else if (clkEn && wrTempEcho) begin
      tempEcho_r <= frameBus.wrData;
    end
  end

  // Receive mode, trigger edge and phase flip position
  always_ff @(posedge clk) begin
    if (rst) begin
      rxPhase_r <= RST_RX_PHASE;
    end else if (clkEn && wrRxPhase) begin
      rxPhase_r <= frameBus.wrData;
    end
  end

  // Amplifier controls and timing value upper bits
  always_ff @(posedge clk) begin
    if (rst) begin
      gainHi_r <= RST_GAIN_HI;
    end else if (clkEn && wrGainHi) begin
      gainHi_r <= frameBus.wrData;
    end
  end

  // Timing value lower byte
  always_ff @(posedge clk) begin
    if (rst) begin
      gainLo_r <= RST_GAIN_LO;
    end else if (clkEn && wrGainLo) begin
      gainLo_r <= frameBus.wrData;
    end
  end

  // ****************************************************************
  // Derived settings
  // ****************************************************************

  wire [2:0] rxCountField = rxCount_r[RX_CNT_LSB +: 3];
  wire [2:0] txDivField = transmit_r[TX_DIV_LSB +: 3];
  wire useTxDiv = tempEcho_r[TE_CLKDIV_BIT];

  // Zero expected events means free running with 32 stop pulses
  wire [5:0] stopCount_nxt = (rxCountField == 3'h0) ? STOP_COUNT_FREE :
    {3'h0, rxCountField};

  // Temperature clock either fixed divide by 8 or the transmit divider
  wire [2:0] tempDiv_nxt =
    useTxDiv ? txDivField : TEMP_DIV8_CODE;

  // Stop pulse count held one cycle behind its field
  always_ff @(posedge clk) begin
    if (rst) begin
      stopCount_r <= STOP_COUNT_FREE;
    end else if (clkEn) begin
      stopCount_r <= stopCount_nxt;
    end
  end

  // Temperature divider code held one cycle behind its source
  always_ff @(posedge clk) begin
    if (rst) begin
      tempDiv_r <= TEMP_DIV8_CODE;
    end else if (clkEn) begin
      tempDiv_r <= tempDiv_nxt;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************

  // Stored contents of the addressed register; unmapped reads zero
  assign frameBus.rdData =
    selTransmit ? transmit_r :
    selRxCount ? rxCount_r :
    selMode ? mode_r :
    selTempEcho ? tempEcho_r :
    selRxPhase ? rxPhase_r :
    selGainHi ? gainHi_r :
    selGainLo ? gainLo_r :
    8'h00;

  // ****************************************************************
  // Field outputs
  // ****************************************************************

  // Transmit settings
  assign transmitFreqDivider = txDivField;
  assign transmitPulseCount = transmit_r[4:0];

  // Receive event counting
  assign expectedRxCount = rxCountField;
  assign eventCountEnable = (rxCountField != 3'h0);
  assign stopPulseCount = stopCount_r;

  // Front end mode
  assign commonModeRefSelect = mode_r[MODE_REF_BIT];
  assign measureTypeSelect = mode_r[MODE_MEAS_BIT];
  assign dampingEnable = mode_r[MODE_DAMP_BIT];

  // ****************************************************************
  // Temperature and echo outputs
  // ****************************************************************

  // Temperature measurement options
  assign tempChannelSelect = tempEcho_r[TE_CHAN_BIT];
  assign sensorTypeSelect = tempEcho_r[TE_SENSOR_BIT];
  assign tempClkUseTxDiv = useTxDiv;
  assign tempClkDivider = tempDiv_r;

  // Power blanking and echo qualification
  assign blankingEnable = tempEcho_r[TE_BLANK_BIT];
  assign echoThresholdCode = tempEcho_r[2:0];

  // Receive mode, trigger edge and phase inversion
  assign receiveModeSelect = rxPhase_r[RP_RXMODE_BIT];
  assign triggerEdgeSelect = rxPhase_r[RP_EDGE_BIT];
  assign phaseFlipPosition = rxPhase_r[4:0];

  // ****************************************************************
  // Amplifier and timing outputs
  // ****************************************************************

  // Amplifier chain
  assign secondAmpGainCode = gainHi_r[GH_GAIN_LSB +: 3];
  assign secondAmpBypass = gainHi_r[GH_BYP2_BIT];
  assign firstAmpBypass = gainHi_r[GH_BYP1_BIT];
  assign firstAmpFeedbackSelect = gainHi_r[GH_FB_BIT];

  // Ten-bit timing value joined from two registers
  assign flightTimeTiming = {gainHi_r[1:0], gainLo_r};

endmodule : ultrasonic_afe_config_regs

// File: test/afe_cfg_regs_sva.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks for the configuration bank
// ****************************************************************
module afe_cfg_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic csbN,
  input wire logic sdoOeN,
  input wire logic [2:0] transmitFreqDivider,
  input wire logic [2:0] expectedRxCount,
  input wire logic eventCountEnable,
  input wire logic [5:0] stopPulseCount,
  input wire logic tempClkUseTxDiv,
  input wire logic [2:0] tempClkDivider,
  input wire logic [4:0] phaseFlipPosition,
  input wire logic [2:0] echoThresholdCode,
  input wire logic [9:0] flightTimeTiming
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  chk_stop_free: assert property (
    clkEn && expectedRxCount == 3'h0 |=> stopPulseCount == 6'h20)
    else $error("stop count not 32 with counting off");
  chk_stop_count: assert property (
    clkEn && expectedRxCount != 3'h0
    |=> stopPulseCount == {3'h0, $past(expectedRxCount)})
    else $error("stop count does not follow expected count");
  chk_event_en: assert property (
    eventCountEnable == (expectedRxCount != 3'h0))
    else $error("event counting enable wrong");
  chk_div_eight: assert property (
    clkEn && !tempClkUseTxDiv |=> tempClkDivider == 3'h2)
    else $error("temperature divider not divide by 8");
  chk_div_follow: assert property (
    clkEn && tempClkUseTxDiv
    |=> tempClkDivider == $past(transmitFreqDivider))
    else $error("temperature divider not transmit divider");
  chk_reset_vals: assert property (
    $fell(rst) |-> phaseFlipPosition == 5'h1F
    && echoThresholdCode == 3'h3 && expectedRxCount == 3'h0
    && flightTimeTiming == 10'h000 && stopPulseCount == 6'h20)
    else $error("field not at default after reset");
  chk_idle_release: assert property (
    (csbN && clkEn) [*4] |-> sdoOeN)
    else $error("data out driven while deselected");
  chk_drive_cause: assert property (
    !sdoOeN |-> !$past(csbN, 2))
    else $error("data out driven without select");
endmodule : afe_cfg_regs_chk

bind ultrasonic_afe_config_regs afe_cfg_regs_chk u_chk (.clk, .rst,
  .clkEn, .csbN, .sdoOeN, .transmitFreqDivider, .expectedRxCount,
  .eventCountEnable, .stopPulseCount, .tempClkUseTxDiv, .tempClkDivider,
  .phaseFlipPosition, .echoThresholdCode, .flightTimeTiming);

// File: test/spi_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Host serial master: one command byte, one data byte
// ****************************************************************
module spi_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] frame,
  input wire logic [3:0] halfPer,
  input wire logic [4:0] stopAt,
  input wire logic sdo,
  input wire logic sdoOeN,
  output logic sclk,
  output logic csbN,
  output logic sdi,
  output logic done,
  output logic [7:0] rdByte
);
  logic lastBit = 1'b0;
  logic lineLvl;

  // Released data line shows the inverse of its last driven bit
  assign lineLvl = sdoOeN ? ~lastBit : sdo;
  always @(posedge clk) begin
    if (!sdoOeN) begin
      lastBit <= sdo;
    end
  end

  // Bits change on the falling edge, stopAt below 16 aborts the frame
  initial begin
    sclk = 1'b0;
    csbN = 1'b1;
    sdi = 1'b0;
    done = 1'b0;
    rdByte = 8'h00;
    forever begin
      @(posedge clk);
      if (go && !done) begin
        csbN <= 1'b0;
        for (int i = 0; i < 16 && i < stopAt; i++) begin
          sclk <= 1'b0;
          sdi <= frame[15 - i]; // MSB first
          repeat (halfPer) @(posedge clk);
          if (i > 7) begin
            rdByte[15 - i] <= lineLvl;
          end
          sclk <= 1'b1;
          repeat (halfPer) @(posedge clk);
        end
        sclk <= 1'b0;
        sdi <= ~sdi;
        repeat (halfPer) @(posedge clk);
        csbN <= 1'b1; // Frame ends with select high
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (halfPer) @(posedge clk);
      end
    end
  end
endmodule : spi_host_model

// File: test/tb.sv
`timescale 1ns/1ns
// ****************************************************************
// Bench for the configuration register bank
// ****************************************************************
module tb;
  import afe_cfg_pkg::*;
  typedef struct {logic [5:0] a; logic [7:0] w, r; logic [9:0] v;} row_t;
  logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, go = 1'b0;
  logic [15:0] frame = 16'h0000;
  logic [3:0] halfPer = 4'h5;
  logic [4:0] stopAt = 5'h10;
  logic sclk, csbN, sdi, sdo, sdoOeN, done;
  logic [7:0] rdByte, rd;
  logic [2:0] transmitFreqDivider, expectedRxCount, tempClkDivider;
  logic [2:0] echoThresholdCode, secondAmpGainCode;
  logic [4:0] transmitPulseCount, phaseFlipPosition;
  logic [5:0] stopPulseCount;
  logic [9:0] flightTimeTiming;
  logic eventCountEnable, commonModeRefSelect, measureTypeSelect;
  logic dampingEnable, tempChannelSelect, sensorTypeSelect;
  logic tempClkUseTxDiv, blankingEnable, receiveModeSelect;
  logic triggerEdgeSelect, secondAmpBypass, firstAmpBypass;
  logic firstAmpFeedbackSelect;
  int failures = 0, num_checks = 0;
  logic [7:0] rstVals [7] = '{8'h45, 8'h40, 8'h00, 8'h03, 8'h1F, 8'h00,
    8'h00};
  // Address, written byte, read back, field outputs
  row_t rows [11] = '{
    '{6'h00, 8'hE3, 8'hE3, 10'h0E3},
    '{6'h01, 8'hC5, 8'hC5, 10'h005}, // Zeros in bits 5..3
    '{6'h02, 8'hE0, 8'hE0, 10'h0E0}, // Zeros in bits 4..0
    '{6'h02, 8'h40, 8'h40, 10'h040},
    '{6'h03, 8'h7F, 8'h7F, 10'h07F},
    '{6'h03, 8'h00, 8'h00, 10'h000},
    '{6'h04, 8'h7E, 8'h7E, 10'h07E}, // Position not 0 or 1
    '{6'h04, 8'h22, 8'h22, 10'h022}, // Position not 0 or 1
    '{6'h05, 8'hFE, 8'hFE, 10'h0FE},
    '{6'h06, 8'hA5, 8'hA5, 10'h2A5},
    '{6'h0A, 8'h5A, 8'h00, 10'h2A5}};

  ultrasonic_afe_config_regs dut (.clk, .rst, .clkEn, .sclk, .csbN, .sdi,
    .sdo, .sdoOeN, .transmitFreqDivider, .transmitPulseCount,
    .expectedRxCount, .eventCountEnable, .stopPulseCount,
    .commonModeRefSelect, .measureTypeSelect, .dampingEnable,
    .tempChannelSelect, .sensorTypeSelect, .tempClkUseTxDiv,
    .tempClkDivider, .blankingEnable, .echoThresholdCode,
    .receiveModeSelect, .triggerEdgeSelect, .phaseFlipPosition,
    .secondAmpGainCode, .secondAmpBypass, .firstAmpBypass,
    .firstAmpFeedbackSelect, .flightTimeTiming);
  spi_host_model host (.clk, .go, .frame, .halfPer, .stopAt, .sdo,
    .sdoOeN, .sclk, .csbN, .sdi, .done, .rdByte);

  // Clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  // Field outputs of one register, packed like the register; any other address gives the ten-bit timing value
  function automatic logic [9:0] view(input logic [5:0] a);
    case (a)
      6'h00: view = {2'h0, transmitFreqDivider, transmitPulseCount};
      6'h01: view = {7'h00, expectedRxCount};
      6'h02: view = {2'h0, commonModeRefSelect, measureTypeSelect,
        dampingEnable, 5'h00};
      6'h03: view = {3'h0, tempChannelSelect, sensorTypeSelect,
        tempClkUseTxDiv, blankingEnable, echoThresholdCode};
      6'h04: view = {3'h0, receiveModeSelect, triggerEdgeSelect,
        phaseFlipPosition};
      6'h05: view = {2'h0, secondAmpGainCode, secondAmpBypass,
        firstAmpBypass, firstAmpFeedbackSelect, flightTimeTiming[9:8]};
      default: view = flightTimeTiming;
    endcase
  endfunction : view

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One host frame, held until the model reports done
  task automatic xfer(input logic [7:0] c, input logic [7:0] d,
    input logic [4:0] s, output logic [7:0] r);
    int n;
    @(posedge clk);
    frame <= {c, d};
    stopAt <= s;
    go <= 1'b1;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge clk);
    go <= 1'b0;
    r = rdByte;
    if (n == 3000) begin
      failures++;
      end_sim();
    end
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer({2'b01, a}, d, 5'h10, rd);
    repeat (4) @(posedge clk);
  endtask : wr

  task automatic rstChk;
    for (int a = 0; a < 7; a++) begin
      xfer({2'b00, 6'(a)}, 8'h00, 5'h10, rd);
      chk(rd, rstVals[a]);
    end
    chk(stopPulseCount, 10'h020);
    chk(tempClkDivider, 10'h002);
    chk(view(6'h02), 10'h000);
    chk(view(6'h03), 10'h003);
    chk(view(6'h04), 10'h01F);
  endtask : rstChk

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rstChk();
    foreach (rows[i]) begin
      halfPer <= (i % 2) ? 4'h9 : 4'h5;
      wr(rows[i].a, rows[i].w);
      xfer({2'b00, rows[i].a}, 8'h00, 5'h10, rd);
      chk(rd, rows[i].r);
      chk(view(rows[i].a), rows[i].v);
    end
    // Every expected receive count code
    for (int k = 0; k < 8; k++) begin
      wr(6'h01, 8'h40 | 8'(k));
      chk(stopPulseCount, (k == 0) ? 10'h020 : 10'(k));
      chk(eventCountEnable, 10'(k != 0));
    end
    // Temperature clock divider source
    wr(6'h00, 8'hA0);
    wr(6'h03, 8'h00);
    chk(tempClkDivider, 10'h002);
    wr(6'h03, 8'h10);
    chk(tempClkDivider, 10'h005);
    // Reserved command bit set, then an aborted frame
    xfer(8'hC2, 8'hFF, 5'h10, rd);
    repeat (6) @(posedge clk);
    chk(view(6'h02), 10'h040);
    xfer(8'h46, 8'h00, 5'h0C, rd);
    repeat (6) @(posedge clk);
    chk(view(6'h06), 10'h2A5);
    wr(6'h06, 8'h3C);
    chk(view(6'h06), 10'h23C);
    // Reset in mid-run with the clock enable low
    @(posedge clk);
    rst <= 1'b1;
    clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    clkEn <= 1'b1;
    repeat (2) @(posedge clk);
    rstChk();
    end_sim();
  end
endmodule : tb
